// ===== lppc_pkg.sv
// Constants shared by the low-power pulse counter: register map, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
`default_nettype none
package lppc_pkg;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned DEB_W = 8;
    localparam int unsigned PH_W = 7;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PULLUP = 8'h04;
    localparam logic [7:0] OFS_DEB_RISE = 8'h08;
    localparam logic [7:0] OFS_DEB_FALL = 8'h0c;
    localparam logic [7:0] OFS_CNT0 = 8'h10;
    localparam logic [7:0] OFS_CNT1 = 8'h14;
    localparam logic [7:0] OFS_THR0 = 8'h18;
    localparam logic [7:0] OFS_THR1 = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Mode register fields
    localparam int unsigned MODE_LSB = 6;
    localparam int unsigned RATE_LSB = 4;
    // Pull-up register fields
    localparam int unsigned DUTY_LSB = 0;
    localparam int unsigned STR_LSB = 2;
    localparam int unsigned CALPORT_BIT = 5;
    localparam int unsigned CALGO_BIT = 6;
    // Status register bits
    localparam int unsigned ST_OVF0 = 0;
    localparam int unsigned ST_MATCH0 = 2;
    localparam int unsigned ST_CALBUSY = 4;
    localparam int unsigned ST_CALFAIL = 5;
    // Reset values
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [5:0] RST_PULLUP = 6'h00;
    localparam logic [DEB_W-1:0] RST_DEB_RISE = 8'h04;
    localparam logic [DEB_W-1:0] RST_DEB_FALL = 8'h04;
    localparam logic [CNT_W-1:0] RST_THR = 24'hffffff;
    // Sample period in timebase ticks at rate code 0 (eight eighths)
    localparam logic [PH_W-1:0] PERIOD_BASE = 7'h08;
    // Pull-up on-time in timebase ticks per duty code (eighths of the period at rate code 0)
    localparam logic [PH_W-1:0] PU_EIGHTHS_0 = 7'h02;
    localparam logic [PH_W-1:0] PU_EIGHTHS_1 = 7'h03;
    localparam logic [PH_W-1:0] PU_EIGHTHS_2 = 7'h04;
    localparam logic [PH_W-1:0] PU_EIGHTHS_3 = 7'h06;
    localparam logic [2:0] STR_OFF = 3'h0;
    localparam logic [2:0] STR_MIN = 3'h1;
    localparam logic [2:0] STR_MAX = 3'h7;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_DUAL = 2'h2,
        MODE_QUAD = 2'h3
    } lppc_mode_e;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'h0,
        CAL_TEST = 2'h1
    } lppc_cal_e;
endpackage
`default_nettype wire

// ===== lppc_reed_model.sv
// Two Form-A reed switches on meter lines that depend on the block's pull-up.
// Assumes the bench sets switch positions and the weakest strength that charges.
`timescale 1ns/1ps
`default_nettype none
module lppc_reed_model (
    input wire logic pullup_en,
    input wire logic [2:0] pullup_strength,
    input wire logic [2:0] need_strength,
    input wire logic closed0,
    input wire logic closed1,
    output logic line0,
    output logic line1
);
    logic charged;
    // Open line reads high only under a strong enough pull-up; without one the
    // wiring leaks to ground, so no stale high lingers
    always_comb begin
        charged = pullup_en && (pullup_strength != 3'h0) && (pullup_strength >= need_strength);
        line0 = !closed0 && charged;
        line1 = !closed1 && charged;
    end
endmodule
`default_nettype wire

// ===== lppc_sva.sv
// Checker for the pulse counter's bus face, pull-up drive and wake flag.
// Sees only lppc_top ports; bound into every lppc_top instance.
`timescale 1ns/1ps
`default_nettype none
module lppc_sva
    import lppc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rtc_timebase_clock,
    input wire logic first_meter_input,
    input wire logic second_meter_input,
    input wire logic pullup_en,
    input wire logic [2:0] pullup_strength,
    input wire logic wake
);
    logic [3:0] mode_q, mode_d;
    logic rtc_q;
    logic [6:0] on_ticks_q, on_ticks_d;
    logic wr_stat, mapped;
    // Shadow of mode bits and pull-up on-time counted in raw timebase edges
    always_comb begin
        wr_stat = psel && penable && pwrite && (paddr == OFS_STATUS);
        mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);
        mode_d = mode_q;
        if (psel && penable && pwrite && (paddr == OFS_MODE)) begin
            mode_d = pwdata[7:4];
        end
        on_ticks_d = 7'h00;
        if (pullup_en) begin
            on_ticks_d = on_ticks_q + {6'h00, rtc_timebase_clock && !rtc_q};
        end
    end
    // Registers of the helper logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 4'h0;
            rtc_q <= 1'b0;
            on_ticks_q <= 7'h00;
        end else begin
            mode_q <= mode_d;
            rtc_q <= rtc_timebase_clock;
            on_ticks_q <= on_ticks_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_zero_wait; s_setup ##1 s_access |-> pready; endproperty
    property p_err_in_access; pslverr |-> psel && penable; endproperty
    property p_err_unmapped; psel && penable && !mapped |-> pslverr; endproperty
    property p_no_err_mapped; psel && penable && mapped |-> !pslverr; endproperty
    property p_refused_rdata; psel && penable && !pwrite && !mapped |-> prdata == 32'h0;
    endproperty
    property p_mode_readback;
        s_setup ##1 s_access ##0 (!pwrite && paddr == OFS_MODE) |-> prdata == {24'h0, mode_q, 4'h0};
    endproperty
    property p_strength_on; pullup_en |-> pullup_strength != 3'h0; endproperty
    property p_wake_clear; $fell(wake) |-> $past(wr_stat); endproperty
    property p_wake_sticky; wake && !wr_stat |=> wake; endproperty
    property p_pullup_duty; on_ticks_q <= 7'h07; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access phase not ready");
    a_err_in_access: assert property (p_err_in_access) else $error("error outside access");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access refused");
    a_refused_rdata: assert property (p_refused_rdata) else $error("refused read not zero");
    a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");
    a_strength_on: assert property (p_strength_on) else $error("pull-up on at code 0");
    a_wake_clear: assert property (p_wake_clear) else $error("wake fell without clear");
    a_wake_sticky: assert property (p_wake_sticky) else $error("wake not sticky");
    a_pullup_duty: assert property (p_pullup_duty) else $error("pull-up on too long");
endmodule
bind lppc_top lppc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_timebase_clock(rtc_timebase_clock),
    .first_meter_input(first_meter_input), .second_meter_input(second_meter_input),
    .pullup_en(pullup_en), .pullup_strength(pullup_strength), .wake(wake));
`default_nettype wire

// ===== lppc_top.sv
// Low-power pulse counter: timebase sampler, pull-up duty control, debounce,
// counting modes, threshold compare, calibration and APB register file.
// Assumes meter inputs and the RTC timebase arrive asynchronously as pins.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lppc_top
    import lppc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rtc_timebase_clock,
    input wire logic first_meter_input,
    input wire logic second_meter_input,
    output logic pullup_en,
    output logic [2:0] pullup_strength,
    output logic wake
);
    // Address decode shared by the read and write paths
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // Quadrature step: bit 0 clockwise, bit 1 counter-clockwise
    function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
        logic [1:0] r;
        r = 2'h0;
        case ({p, c})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'h1;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'h2;
            default: r = 2'h0;
        endcase
        quad_step = r;
    endfunction

    logic wr_en, rd_setup, addr_ok;
    logic [3:0] mode_q, mode_d;
    logic [5:0] pull_q, pull_d;
    logic [DEB_W-1:0] deb_rise_q, deb_rise_d, deb_fall_q, deb_fall_d;
    logic [CNT_W-1:0] thr_q [2];
    logic [CNT_W-1:0] thr_d [2];
    logic [CNT_W-1:0] cnt_q [2];
    logic [5:0] status_q, status_d;
    logic [31:0] prdata_q, prdata_d;
    logic [2:0] rtc_sync_q, rtc_sync_d;
    logic [1:0] in_s1_q, in_s2_q, in_s1_d, in_s2_d;
    logic tick;
    logic [PH_W-1:0] phase_q, phase_d, period_len, pu_len;
    logic sample_stb, pu_win;
    logic pu_en_q, pu_en_d;
    lppc_cal_e cal_q, cal_d;
    logic cal_busy, cal_fail_ev;
    logic [2:0] cal_str;
    logic [1:0] deb_q, deb_prev_q, deb_prev_d;
    logic [1:0] inc, ovf_ev, match_ev;
    logic clr_cnt, count_ok;
    lppc_mode_e mode_sel;

    // APB: zero wait states; read data latched in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign addr_ok = reg_hit(paddr, OFS_MODE) | reg_hit(paddr, OFS_PULLUP)
        | reg_hit(paddr, OFS_DEB_RISE) | reg_hit(paddr, OFS_DEB_FALL)
        | reg_hit(paddr, OFS_CNT0) | reg_hit(paddr, OFS_CNT1)
        | reg_hit(paddr, OFS_THR0) | reg_hit(paddr, OFS_THR1)
        | reg_hit(paddr, OFS_STATUS);
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_q;
    assign mode_sel = lppc_mode_e'(mode_q[3:2]);
    assign cal_busy = (cal_q == CAL_TEST);

    // Read mux; unmapped and reserved bits read as zero
    always_comb begin
        prdata_d = prdata_q;
        if (rd_setup) begin
            prdata_d = 32'h0;
            if (reg_hit(paddr, OFS_MODE)) prdata_d[7:4] = mode_q;
            if (reg_hit(paddr, OFS_PULLUP)) prdata_d[5:0] = pull_q;
            if (reg_hit(paddr, OFS_DEB_RISE)) prdata_d[DEB_W-1:0] = deb_rise_q;
            if (reg_hit(paddr, OFS_DEB_FALL)) prdata_d[DEB_W-1:0] = deb_fall_q;
            if (reg_hit(paddr, OFS_CNT0)) prdata_d[CNT_W-1:0] = cnt_q[0];
            if (reg_hit(paddr, OFS_CNT1)) prdata_d[CNT_W-1:0] = cnt_q[1];
            if (reg_hit(paddr, OFS_THR0)) prdata_d[CNT_W-1:0] = thr_q[0];
            if (reg_hit(paddr, OFS_THR1)) prdata_d[CNT_W-1:0] = thr_q[1];
            if (reg_hit(paddr, OFS_STATUS)) prdata_d[5:0] = status_q;
        end
    end

    // Synchronisers for the timebase and both meter pins
    always_comb begin
        rtc_sync_d = {rtc_sync_q[1:0], rtc_timebase_clock};
        in_s1_d = {second_meter_input, first_meter_input};
        in_s2_d = in_s1_q;
    end
    // Only stages two and three feed the edge detector
    assign tick = rtc_sync_q[1] & ~rtc_sync_q[2];

    // Sample-period phase, counted in timebase ticks
    always_comb begin
        period_len = PH_W'(PERIOD_BASE << mode_q[1:0]);
        // On-time fixed in ticks, so a slower rate also cuts average current
        case (pull_q[1:0])
            2'h0: pu_len = PU_EIGHTHS_0;
            2'h1: pu_len = PU_EIGHTHS_1;
            2'h2: pu_len = PU_EIGHTHS_2;
            default: pu_len = PU_EIGHTHS_3;
        endcase
        phase_d = phase_q;
        if (tick) begin
            phase_d = (phase_q >= period_len - 7'h01) ? 7'h00 : phase_q + 7'h01;
        end
    end
    // Sample at the last tick of the charge window, once the line settled
    assign pu_win = (phase_q < pu_len);
    assign sample_stb = tick & (phase_q == pu_len - 7'h01);

    // Pull-up drive; strength code zero keeps it off, idle mode saves power
    always_comb begin
        pu_en_d = pu_win & (pull_q[4:2] != STR_OFF)
            & ((mode_sel != MODE_OFF) | cal_busy);
    end
    assign pullup_en = pu_en_q;
    assign pullup_strength = pull_q[4:2];

    // Calibration: step strength up until the open switch reads high
    always_comb begin
        cal_d = cal_q;
        cal_str = pull_q[4:2];
        cal_fail_ev = 1'b0;
        case (cal_q)
            CAL_IDLE: begin
                if (wr_en && reg_hit(paddr, OFS_PULLUP) && pwdata[CALGO_BIT]) begin
                    cal_d = CAL_TEST;
                    cal_str = STR_MIN;
                end
            end
            CAL_TEST: begin
                if (sample_stb) begin
                    if (in_s2_q[pull_q[CALPORT_BIT]]) begin
                        cal_d = CAL_IDLE;
                    end else if (pull_q[4:2] == STR_MAX) begin
                        cal_d = CAL_IDLE;
                        cal_fail_ev = 1'b1;
                    end else begin
                        cal_str = pull_q[4:2] + 3'h1;
                    end
                end
            end
            default: cal_d = CAL_IDLE;
        endcase
    end

    // Software-written registers; calibration owns strength while busy
    always_comb begin
        mode_d = mode_q;
        pull_d = pull_q;
        deb_rise_d = deb_rise_q;
        deb_fall_d = deb_fall_q;
        thr_d[0] = thr_q[0];
        thr_d[1] = thr_q[1];
        clr_cnt = 1'b0;
        if (wr_en) begin
            if (reg_hit(paddr, OFS_MODE)) begin
                mode_d = pwdata[7:4];
                clr_cnt = 1'b1;
            end
            if (reg_hit(paddr, OFS_PULLUP) && !cal_busy) pull_d = pwdata[5:0];
            if (reg_hit(paddr, OFS_DEB_RISE)) deb_rise_d = pwdata[DEB_W-1:0];
            if (reg_hit(paddr, OFS_DEB_FALL)) deb_fall_d = pwdata[DEB_W-1:0];
            if (reg_hit(paddr, OFS_THR0)) thr_d[0] = pwdata[CNT_W-1:0];
            if (reg_hit(paddr, OFS_THR1)) thr_d[1] = pwdata[CNT_W-1:0];
        end
        // Counter offsets decode but take no write data
        if (cal_busy || cal_d == CAL_TEST) pull_d[4:2] = cal_str;
    end

    // Debounce integrators, one per input, sharing both thresholds
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_deb
            logic [DEB_W-1:0] integ_q, integ_d;
            logic out_q, out_d;
            always_comb begin
                integ_d = integ_q;
                out_d = out_q;
                // Frozen during calibration so charging tests do not count
                if (sample_stb && !cal_busy) begin
                    if (out_q) begin
                        if (!in_s2_q[ch]) begin
                            if (integ_q <= 8'h01) begin
                                integ_d = 8'h00;
                                out_d = 1'b0;
                            end else begin
                                integ_d = integ_q - 8'h01;
                            end
                        end else if (integ_q < deb_fall_q) begin
                            integ_d = integ_q + 8'h01;
                        end
                    end else begin
                        if (in_s2_q[ch]) begin
                            if ({1'b0, integ_q} + 9'h001 >= {1'b0, deb_rise_q}) begin
                                out_d = 1'b1;
                                integ_d = deb_fall_q;
                            end else begin
                                integ_d = integ_q + 8'h01;
                            end
                        end else if (integ_q != 8'h00) begin
                            integ_d = integ_q - 8'h01;
                        end
                    end
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    integ_q <= 8'h00;
                    out_q <= 1'b1;
                end else begin
                    integ_q <= integ_d;
                    out_q <= out_d;
                end
            end
            assign deb_q[ch] = out_q;
        end
    endgenerate

    // Count events by mode; rising edge of the filtered line is one pulse
    always_comb begin
        deb_prev_d = deb_q;
        count_ok = (mode_sel != MODE_OFF) & ~cal_busy;
        inc = 2'h0;
        case (mode_sel)
            MODE_SINGLE: inc[0] = deb_q[0] & ~deb_prev_q[0];
            MODE_DUAL: inc = deb_q & ~deb_prev_q;
            MODE_QUAD: inc = quad_step(deb_prev_q, deb_q);
            default: inc = 2'h0;
        endcase
        if (!count_ok || clr_cnt) inc = 2'h0;
    end

    // Two up-counters with threshold compare
    generate
        for (ch = 0; ch < 2; ch++) begin : g_cnt
            logic [CNT_W-1:0] c_d;
            always_comb begin
                c_d = cnt_q[ch];
                ovf_ev[ch] = 1'b0;
                match_ev[ch] = 1'b0;
                if (clr_cnt) begin
                    c_d = 24'h000000;
                end else if (inc[ch]) begin
                    c_d = cnt_q[ch] + 24'h000001;
                    ovf_ev[ch] = (cnt_q[ch] == 24'hffffff);
                    match_ev[ch] = (c_d == thr_q[ch]);
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q[ch] <= 24'h000000;
                end else begin
                    cnt_q[ch] <= c_d;
                end
            end
        end
    endgenerate

    // Sticky flags except cal-busy, which tracks calibration; write one to clear; a new event wins over the clear
    always_comb begin
        status_d = status_q;
        if (wr_en && reg_hit(paddr, OFS_STATUS)) begin
            status_d = status_q & ~pwdata[5:0];
        end
        status_d[ST_OVF0 +: 2] = status_d[ST_OVF0 +: 2] | ovf_ev;
        status_d[ST_MATCH0 +: 2] = status_d[ST_MATCH0 +: 2] | match_ev;
        status_d[ST_CALFAIL] = status_d[ST_CALFAIL] | cal_fail_ev;
        status_d[ST_CALBUSY] = (cal_d == CAL_TEST);
    end
    // Wake follows any pending overflow or match
    assign wake = |status_q[3:0];

    // Register stage for the logic above; debounce and counters hold their own flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= RST_MODE;
            pull_q <= RST_PULLUP;
            deb_rise_q <= RST_DEB_RISE;
            deb_fall_q <= RST_DEB_FALL;
            thr_q[0] <= RST_THR;
            thr_q[1] <= RST_THR;
            status_q <= 6'h00;
            prdata_q <= 32'h0;
            rtc_sync_q <= 3'h0;
            in_s1_q <= 2'h3;
            in_s2_q <= 2'h3;
            phase_q <= 7'h00;
            pu_en_q <= 1'b0;
            cal_q <= CAL_IDLE;
            deb_prev_q <= 2'h3;
        end else begin
            mode_q <= mode_d;
            pull_q <= pull_d;
            deb_rise_q <= deb_rise_d;
            deb_fall_q <= deb_fall_d;
            thr_q[0] <= thr_d[0];
            thr_q[1] <= thr_d[1];
            status_q <= status_d;
            prdata_q <= prdata_d;
            rtc_sync_q <= rtc_sync_d;
            in_s1_q <= in_s1_d;
            in_s2_q <= in_s2_d;
            phase_q <= phase_d;
            pu_en_q <= pu_en_d;
            cal_q <= cal_d;
            deb_prev_q <= deb_prev_d;
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for lppc_top with the reed switch model on its pins.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lppc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic rtc = 1'b0, closed0 = 1'b0, closed1 = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] rtc_div = 3'h0, need = 3'h1, pullup_strength;
    logic pready, pslverr, line0, line1, pullup_en, wake;
    int mismatches = 0, checks = 0;
    lppc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtc_timebase_clock(rtc), .first_meter_input(line0),
        .second_meter_input(line1), .pullup_en(pullup_en), .pullup_strength(pullup_strength),
        .wake(wake));
    lppc_reed_model reed (.pullup_en(pullup_en), .pullup_strength(pullup_strength),
        .need_strength(need), .closed0(closed0), .closed1(closed1), .line0(line0), .line1(line1));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // Slow timebase, one period per eight bus cycles, never stopped
    always @(posedge pclk) begin
        rtc_div <= rtc_div + 3'h1;
        rtc <= rtc_div[2];
    end
    task automatic stop_test;
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus transfer; waits for ready at most 20 edges
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask
    // Holds a switch position long enough for several samples
    task automatic hold(input logic c0, input logic c1);
        closed0 <= c0;
        closed1 <= c1;
        repeat (300) @(posedge pclk);
    endtask
    task automatic t_reset_refused;
        logic [31:0] r;
        logic e;
        rd_chk(OFS_MODE, 32'h0);
        rd_chk(OFS_DEB_RISE, 32'h4);
        rd_chk(OFS_DEB_FALL, 32'h4);
        rd_chk(OFS_THR0, 32'hffffff);
        rd_chk(OFS_CNT1, 32'h0);
        apb(1'b0, 8'h24, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
        apb(1'b1, 8'h06, 32'h5, r, e);
        check({31'h0, e}, 32'h1);
    endtask
    // Single mode: three pulses, threshold 2 sets the sticky match flag
    task automatic t_single;
        wr(OFS_DEB_RISE, 32'h1);
        wr(OFS_DEB_FALL, 32'h1);
        wr(OFS_PULLUP, 32'h04);
        wr(OFS_THR0, 32'h2);
        wr(OFS_MODE, 32'h40);
        hold(1'b0, 1'b0);
        wr(OFS_MODE, 32'h40);
        repeat (3) begin
            hold(1'b1, 1'b1);
            hold(1'b0, 1'b0);
        end
        wr(OFS_CNT0, 32'h0);
        rd_chk(OFS_CNT0, 32'h3);
        rd_chk(OFS_CNT1, 32'h0);
        rd_chk(OFS_STATUS, 32'h4);
        check({31'h0, wake}, 32'h1);
        wr(OFS_STATUS, 32'h4);
        rd_chk(OFS_STATUS, 32'h0);
        check({31'h0, wake}, 32'h0);
    endtask
    task automatic t_dual;
        wr(OFS_MODE, 32'h80);
        rd_chk(OFS_CNT0, 32'h0);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
        repeat (2) begin
            hold(1'b0, 1'b1);
            hold(1'b0, 1'b0);
        end
        rd_chk(OFS_CNT0, 32'h1);
        rd_chk(OFS_CNT1, 32'h2);
    endtask
    // Quadrature: one turn each way, four steps per turn
    task automatic t_quad;
        wr(OFS_MODE, 32'hc0);
        hold(1'b0, 1'b1);
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
        rd_chk(OFS_CNT0, 32'h4);
        rd_chk(OFS_CNT1, 32'h0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
        hold(1'b0, 1'b1);
        hold(1'b0, 1'b0);
        rd_chk(OFS_CNT1, 32'h4);
        rd_chk(OFS_CNT0, 32'h4);
    endtask
    task automatic t_off_cal;
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        wr(OFS_MODE, 32'h00);
        hold(1'b1, 1'b1);
        hold(1'b0, 1'b0);
        rd_chk(OFS_CNT0, 32'h0);
        check({31'h0, pullup_en}, 32'h0);
        need <= 3'h3;
        wr(OFS_STATUS, 32'h3f);
        wr(OFS_PULLUP, 32'h40);
        r = 32'h10;
        while (r[ST_CALBUSY] && n < 400) begin
            apb(1'b0, OFS_STATUS, 32'h0, r, e);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            stop_test();
        end
        rd_chk(OFS_PULLUP, 32'h0c);
        check({29'h0, pullup_strength}, 32'h3);
        rd_chk(OFS_STATUS, 32'h0);
    endtask
    // Main sequence: reset held for twelve cycles, then each scenario
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_refused();
        t_single();
        t_dual();
        t_quad();
        t_off_cal();
        stop_test();
    end
endmodule
`default_nettype wire
